//--- inc/ryc_consts.svh
`ifndef RYC_CONSTS_SVH
`define RYC_CONSTS_SVH

// Register indices; byte address is four times the index
`define RYC_IDX_YEAR       5'h09
`define RYC_IDX_CTRL_A     5'h0a
`define RYC_IDX_CTRL_B     5'h0b
`define RYC_IDX_STATUS     5'h0c
`define RYC_IDX_BLOCK      5'h10

// Update and rate control fields
`define RYC_A_PEND_BIT     7
`define RYC_A_DCC_HI       6
`define RYC_A_DCC_LO       4
`define RYC_A_RATE_HI      3
`define RYC_A_RATE_LO      0

// Update inhibit, interrupt and format control fields
`define RYC_B_FREEZE_BIT   7
`define RYC_B_PIE_BIT      6
`define RYC_B_AIE_BIT      5
`define RYC_B_UIE_BIT      4
`define RYC_B_BIN_BIT      2
`define RYC_B_H24_BIT      1
`define RYC_B_DST_BIT      0

// Status flag fields
`define RYC_S_IRQ_BIT      7
`define RYC_S_PF_BIT       6
`define RYC_S_AF_BIT       5
`define RYC_S_UF_BIT       4

// Block control field
`define RYC_K_EN_BIT       0

// Reset values
`define RYC_RST_YEAR       8'h00
`define RYC_RST_DCC        3'h0
`define RYC_RST_RATE       4'h0
`define RYC_RST_CTRL_B     8'h00
`define RYC_RST_FLAGS      3'h0
`define RYC_RST_DIV        15'h0000

// Year range
`define RYC_YEAR_MAX       8'h63

// Timing in 32 kHz ticks
`define RYC_PEND_TICKS     15'h0010
`define RYC_DIV_LAST       15'h7fff
`define RYC_DIV_RESTART    15'h4000

`endif

//--- inc/ryc_pkg.sv
package ryc_pkg;
	typedef logic [7:0]  ryc_byte_type;
	typedef logic [14:0] ryc_div_type;
	typedef logic [3:0]  ryc_rate_type;
	typedef logic [4:0]  ryc_index_type;
	typedef enum logic [2:0] {
		RYC_DCC_RESERVED = 3'h0,
		RYC_DCC_NORMAL   = 3'h2,
		RYC_DCC_HALT_A   = 3'h6,
		RYC_DCC_HALT_B   = 3'h7
	} ryc_dcc_type;
endpackage : ryc_pkg

//--- rtl/ryc_regs.sv
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ryc_consts.svh"

module ryc_regs (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	// Avalon-MM slave
	input  wire logic [6:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// 32 kHz clock pin
	input  wire logic                  clk32k_in,
	// Calendar side events
	input  wire logic                  alarm_match,
	input  wire logic                  year_carry,
	// Time and date counter control
	output logic                       update_tick,
	output logic                       update_pending,
	output logic                       periodic_event,
	output logic                       binary_mode,
	output logic                       hour_24_mode,
	output logic                       dst_enable,
	// Interrupt
	output logic                       irq
);
	import ryc_pkg::*;
	default clocking ryc_cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// Pin synchroniser and filtered level
	logic [2:0]    sync32;
	logic          lvl32;
	logic          next_lvl32;
	logic          tick32;

	always_comb begin
		next_lvl32 = lvl32;
		if (sync32[1] == sync32[2]) begin
			next_lvl32 = sync32[2];
		end
		tick32 = next_lvl32 & ~lvl32;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sync32 <= 3'h0;
			lvl32  <= 1'b0;
		end else begin
			sync32 <= {sync32[1:0], clk32k_in};
			lvl32  <= next_lvl32;
		end
	end

	// Register state
	ryc_byte_type  year;
	ryc_dcc_type   dcc;
	ryc_rate_type  rate;
	ryc_byte_type  ctrl_b;
	logic [2:0]    flags;
	logic          blk_en;
	ryc_div_type   div;
	logic          ack;
	logic [2:0]    rd_flags;
	ryc_byte_type  next_year;
	ryc_dcc_type   next_dcc;
	ryc_rate_type  next_rate;
	ryc_byte_type  next_ctrl_b;
	logic [2:0]    next_flags;
	logic          next_blk_en;
	ryc_div_type   next_div;
	logic          next_ack;
	logic [2:0]    next_rd_flags;
	logic [31:0]   next_readdata;
	logic          next_pending;
	logic          next_update;
	logic          next_periodic;

	ryc_index_type idx;
	logic          wr_go;
	logic          rd_go;
	logic          wr_lo;
	logic          running;
	logic          halted;
	logic          freeze;
	ryc_div_type   pmask;
	ryc_byte_type  wr_byte;
	ryc_byte_type  year_bin;
	ryc_byte_type  year_view;
	ryc_byte_type  reg_a_view;
	ryc_byte_type  status_view;

	function automatic ryc_byte_type ryc_to_bcd(input ryc_byte_type v);
		ryc_byte_type tens;
		tens = v / 8'h0a;
		ryc_to_bcd = {tens[3:0], 4'(v - tens * 8'h0a)};
	endfunction : ryc_to_bcd

	function automatic ryc_byte_type ryc_from_bcd(input ryc_byte_type v);
		ryc_from_bcd = 8'({4'h0, v[7:4]} * 8'h0a) + {4'h0, v[3:0]};
	endfunction : ryc_from_bcd

	// Periodic mask: low codes alias the coarser rates
	function automatic ryc_div_type ryc_pmask(input ryc_rate_type c);
		logic [3:0] sh;
		sh = (c < 4'h3) ? 4'(c + 4'h6) : 4'(c - 4'h1);
		ryc_pmask = 15'((16'h0001 << sh) - 16'h0001);
	endfunction : ryc_pmask

	always_comb begin
		idx         = avs_address[6:2];
		wr_go       = avs_write & ack;
		rd_go       = avs_read & ack;
		wr_lo       = wr_go & avs_byteenable[0];
		wr_byte     = avs_writedata[7:0];
		freeze      = ctrl_b[`RYC_B_FREEZE_BIT];
		halted      = (dcc == RYC_DCC_HALT_A) || (dcc == RYC_DCC_HALT_B);
		running     = (dcc == RYC_DCC_NORMAL) && blk_en;
		pmask       = ryc_pmask(rate);
		binary_mode = ctrl_b[`RYC_B_BIN_BIT];
		// Only conversion follows these bits; storage stays binary
		year_view   = binary_mode ? year : ryc_to_bcd(year);
		year_bin    = binary_mode ? wr_byte : ryc_from_bcd(wr_byte);
		reg_a_view  = {update_pending, dcc, rate};
		status_view = {irq, flags, 4'h0};
	end

	// Bus side: one wait state, data valid with waitrequest low
	always_comb begin
		avs_waitrequest = (avs_read | avs_write) & ~ack;
		next_ack        = (avs_read ^ avs_write) & ~ack;
		next_rd_flags   = rd_flags;
		next_readdata   = avs_readdata;
		if (avs_read && !ack) begin
			next_rd_flags = 3'h0;
			unique case (idx)
				`RYC_IDX_YEAR:   next_readdata = {24'h00_0000, year_view};
				`RYC_IDX_CTRL_A: next_readdata = {24'h00_0000, reg_a_view};
				`RYC_IDX_CTRL_B: next_readdata = {24'h00_0000, ctrl_b[7:4],
						1'b0, ctrl_b[2:0]};
				`RYC_IDX_STATUS: begin
					next_readdata = {24'h00_0000, status_view};
					next_rd_flags = flags;
				end
				`RYC_IDX_BLOCK:  next_readdata = {31'h0000_0000, blk_en};
				default:         next_readdata = 32'h0000_0000;
			endcase
		end
	end

	// Divider chain, update timing and periodic events
	always_comb begin
		next_div      = div;
		next_pending  = update_pending;
		next_update   = 1'b0;
		next_periodic = 1'b0;
		if (halted) begin
			next_div = `RYC_RST_DIV;
		end else if (running && tick32) begin
			next_div = 15'(div + 15'h0001);
			next_periodic = (rate != 4'h0) && ((div & pmask) == pmask);
			if (!freeze) begin
				if (div == 15'(`RYC_DIV_LAST - `RYC_PEND_TICKS)) begin
					next_pending = 1'b1;
				end
				// Update only at the end of a pending window
				if (div == `RYC_DIV_LAST && update_pending) begin
					next_update = 1'b1;
				end
			end
		end
		if (next_update || freeze || !running) begin
			next_pending = 1'b0;
		end
		if (wr_lo && idx == `RYC_IDX_CTRL_A && halted &&
				wr_byte[6:4] == RYC_DCC_NORMAL) begin
			next_div = `RYC_DIV_RESTART;
		end
	end

	// Software registers and sticky flags
	always_comb begin
		next_year   = year;
		next_dcc    = dcc;
		next_rate   = rate;
		next_ctrl_b = ctrl_b;
		next_blk_en = blk_en;
		next_flags  = flags;
		if (year_carry) begin
			next_year = (year >= `RYC_YEAR_MAX) ? 8'h00 :
				8'(year + 8'h01);
		end
		if (wr_lo) begin
			unique case (idx)
				`RYC_IDX_YEAR: next_year = (year_bin > `RYC_YEAR_MAX) ?
					8'h00 : year_bin;
				`RYC_IDX_CTRL_A: begin
					next_dcc  = ryc_dcc_type'(wr_byte[6:4]);
					next_rate = wr_byte[3:0];
				end
				`RYC_IDX_CTRL_B: next_ctrl_b = {wr_byte[7:4], 1'b0,
					wr_byte[2:0]};
				`RYC_IDX_BLOCK:  next_blk_en = wr_byte[`RYC_K_EN_BIT];
				default:         next_ctrl_b = ctrl_b;
			endcase
		end
		// Clear only what the read returned, so late events survive
		if (rd_go && idx == `RYC_IDX_STATUS) begin
			next_flags = flags & ~rd_flags;
		end
		next_flags = next_flags | {periodic_event, alarm_match,
			update_tick};
	end

	always_comb begin
		hour_24_mode = ctrl_b[`RYC_B_H24_BIT];
		dst_enable   = ctrl_b[`RYC_B_DST_BIT];
		irq = (flags[2] & ctrl_b[`RYC_B_PIE_BIT]) |
			(flags[1] & ctrl_b[`RYC_B_AIE_BIT]) |
			(flags[0] & ctrl_b[`RYC_B_UIE_BIT]);
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			year           <= `RYC_RST_YEAR;
			dcc            <= RYC_DCC_RESERVED;
			rate           <= `RYC_RST_RATE;
			ctrl_b         <= `RYC_RST_CTRL_B;
			blk_en         <= 1'b0;
			flags          <= `RYC_RST_FLAGS;
			div            <= `RYC_RST_DIV;
			ack            <= 1'b0;
			rd_flags       <= 3'h0;
			avs_readdata   <= 32'h0000_0000;
			update_pending <= 1'b0;
			update_tick    <= 1'b0;
			periodic_event <= 1'b0;
		end else begin
			year           <= next_year;
			dcc            <= next_dcc;
			rate           <= next_rate;
			ctrl_b         <= next_ctrl_b;
			blk_en         <= next_blk_en;
			flags          <= next_flags;
			div            <= next_div;
			ack            <= next_ack;
			rd_flags       <= next_rd_flags;
			avs_readdata   <= next_readdata;
			update_pending <= next_pending;
			update_tick    <= next_update;
			periodic_event <= next_periodic;
		end
	end

	// Helper: 32 kHz ticks seen while pending is high
	logic [4:0] pend_ticks;
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !update_pending) begin
			pend_ticks <= 5'h00;
		end else if (tick32) begin
			pend_ticks <= 5'(pend_ticks + 5'h01);
		end
	end

	sequence s_restart_write;
		wr_lo && idx == `RYC_IDX_CTRL_A && halted && wr_byte[6:4] == 3'h2;
	endsequence

	sequence s_restarted;
		div == `RYC_DIV_RESTART;
	endsequence

	sequence s_status_read;
		rd_go && idx == `RYC_IDX_STATUS;
	endsequence

	a_pend_before_upd: assert property (update_tick |->
		$past(update_pending)) else $error("update without pending");
	a_pend_length: assert property (update_tick |->
		$past(pend_ticks) == 5'h0f) else $error("pending window length");
	a_pend_clear: assert property (update_tick |->
		!update_pending) else $error("pending not cleared");
	a_pend_rise: assert property ($rose(update_pending) |->
		div == 15'h7ff0) else $error("pending rose at wrong count");
	a_halt_stops: assert property (halted &&
		!(wr_lo && idx == `RYC_IDX_CTRL_A) |=> !update_tick &&
		div == 15'h0000) else $error("halt ignored");
	a_halt_no_event: assert property (halted |=>
		!periodic_event) else $error("periodic event while halted");
	a_restart_delay: assert property (s_restart_write |=>
		s_restarted) else $error("restart offset wrong");
	a_run_needs_en: assert property (update_tick |->
		$past(blk_en) && $past(dcc) == RYC_DCC_NORMAL)
		else $error("update while stopped");
	a_code0_silent: assert property (rate == 4'h0 |=>
		!periodic_event) else $error("event with rate code 0");
	a_freeze_blocks: assert property ($past(freeze) |->
		!update_tick) else $error("update while frozen");
	a_freeze_pend: assert property (freeze |=>
		!update_pending) else $error("pending while frozen");
	a_periodic_irq: assert property (periodic_event &&
		ctrl_b[`RYC_B_PIE_BIT] && !wr_lo |=> irq)
		else $error("periodic irq missing");
	a_flag_sticky: assert property ((alarm_match || update_tick) |=>
		flags[1] || flags[0]) else $error("event flag lost");
	a_upd_flag: assert property (update_tick |=> flags[0])
		else $error("update flag lost");
	a_pe_flag: assert property (periodic_event |=> flags[2])
		else $error("periodic flag lost");
	a_status_clear: assert property (s_status_read ##0
		!(alarm_match || update_tick || periodic_event) |=>
		(flags & $past(rd_flags)) == 3'h0) else $error("status not cleared");
	a_format_only: assert property (wr_lo && !year_carry &&
		idx == `RYC_IDX_CTRL_B |=> $stable(year))
		else $error("year changed by format write");
	a_year_range: assert property (year <= `RYC_YEAR_MAX)
		else $error("year out of range");
	a_year_wrap: assert property (year_carry && !wr_lo &&
		year == `RYC_YEAR_MAX |=> year == 8'h00) else $error("year wrap");

endmodule : ryc_regs

`default_nettype wire

//--- tb/ryc_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ryc_regs_bench;
	import ryc_pkg::*;
	logic                ref_clk = 1'b0;
	logic                reset_n = 1'b0;
	logic         [6:0]  avs_address = 7'h00;
	logic                avs_read = 1'b0;
	logic                avs_write = 1'b0;
	logic         [31:0] avs_writedata = 32'h0000_0000;
	logic         [3:0]  avs_byteenable = 4'hf;
	logic         [31:0] avs_readdata;
	logic                avs_waitrequest;
	logic                clk32k_in = 1'b0;
	logic                alarm_match = 1'b0;
	logic                year_carry = 1'b0;
	logic                update_tick, update_pending, periodic_event;
	logic                binary_mode, hour_24_mode, dst_enable, irq;
	logic         [1:0]  ph = 2'h0;
	logic                pend_d = 1'b0;
	int                  errors = 0, check_count = 0;
	int                  cyc = 0, t_pend = 0, t_upd = 0, n_upd = 0;
	int                  t_go, t0, t1, k, y;
	ryc_byte_type        exp_q[$], msk_q[$];

	ryc_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .clk32k_in(clk32k_in),
		.alarm_match(alarm_match), .year_carry(year_carry),
		.update_tick(update_tick), .update_pending(update_pending),
		.periodic_event(periodic_event), .binary_mode(binary_mode),
		.hour_24_mode(hour_24_mode), .dst_enable(dst_enable), .irq(irq));

	always #5 ref_clk = ~ref_clk;

	// Pin toggles every two cycles: one tick per four cycles keeps runs short
	always @(posedge ref_clk) begin
		ph <= ph + 2'h1;
		clk32k_in <= ph[1];
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Monitor: read results against queued notes, update timing
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (update_pending === 1'b1 && !pend_d)
			t_pend <= cyc;
		pend_d <= (update_pending === 1'b1);
		if (update_tick === 1'b1) begin
			t_upd <= cyc;
			n_upd <= n_upd + 1;
		end
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			chk("readdata", {24'h0, exp_q.pop_front()},
				avs_readdata & {24'hff_ffff, msk_q.pop_front()});
	end

	task automatic bus(input logic wr, input logic [6:0] a,
			input ryc_byte_type d, input ryc_byte_type m = 8'hff);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		if (wr)
			avs_write <= 1'b1;
		else begin
			avs_read <= 1'b1;
			exp_q.push_back(d & m);
			msk_q.push_back(m);
		end
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
			chk("waitrequest", 0, 1);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic pulse_alarm;
		@(posedge ref_clk);
		alarm_match <= 1'b1;
		@(posedge ref_clk);
		alarm_match <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : pulse_alarm

	task automatic wait_pe(output int t);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (periodic_event !== 1'b1 && n < 40000);
		t = cyc;
	endtask : wait_pe

	task automatic count_pe(input int len, output int c);
		c = 0;
		repeat (len) begin
			@(posedge ref_clk);
			if (periodic_event !== 1'b0)
				c++;
		end
	endtask : count_pe

	function automatic ryc_byte_type bcd(input int v);
		return ryc_byte_type'(((v / 10) << 4) | (v % 10));
	endfunction : bcd

	initial begin
		repeat (90000) @(posedge ref_clk);
		errors++;
		print_verdict();
	end

	initial begin
		void'($urandom(32'h311c));
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		bus(0, 7'h24, 8'h00);
		bus(0, 7'h28, 8'h00);
		bus(0, 7'h2c, 8'h00);
		bus(0, 7'h30, 8'h00);
		bus(1, 7'h3c, 8'h5a);
		bus(0, 7'h3c, 8'h00);
		$display("test reset done");
		bus(1, 7'h2c, 8'h07);
		@(posedge ref_clk);
		chk("formats", 3'h7, {binary_mode, hour_24_mode, dst_enable});
		bus(1, 7'h24, 8'h63);
		bus(1, 7'h2c, 8'h00);
		@(posedge ref_clk);
		chk("formats", 3'h0, {binary_mode, hour_24_mode, dst_enable});
		bus(0, 7'h24, 8'h99);
		@(posedge ref_clk);
		year_carry <= 1'b1;
		@(posedge ref_clk);
		year_carry <= 1'b0;
		bus(0, 7'h24, 8'h00);
		y = $urandom % 100;
		bus(1, 7'h24, bcd(y));
		avs_byteenable <= 4'he;
		bus(1, 7'h24, 8'h11);
		avs_byteenable <= 4'hf;
		bus(1, 7'h2c, 8'h04);
		bus(0, 7'h24, ryc_byte_type'(y));
		$display("test year done");
		pulse_alarm();
		chk("irq", 0, irq);
		bus(0, 7'h30, 8'h20);
		bus(0, 7'h30, 8'h00);
		bus(1, 7'h2c, 8'h20);
		pulse_alarm();
		chk("irq", 1, irq);
		bus(0, 7'h30, 8'ha0);
		@(posedge ref_clk);
		chk("irq", 0, irq);
		$display("test events done");
		bus(1, 7'h28, 8'h23);
		count_pe(200, k);
		chk("idle events", 0, k);
		bus(1, 7'h28, 8'h60);
		bus(0, 7'h28, 8'h60);
		bus(1, 7'h40, 8'h01);
		bus(1, 7'h2c, 8'h10);
		bus(1, 7'h28, 8'h20);
		t_go = cyc;
		count_pe(2000, k);
		chk("code 0 events", 0, k);
		for (int c = 1; c <= 12; c++) begin
			bus(1, 7'h28, {4'h2, 4'(c)});
			// Skip an event launched under the old code
			@(posedge ref_clk);
			wait_pe(t0);
			wait_pe(t1);
			chk("period", 4 * (1 << ((c < 3) ? c + 6 : c - 1)), t1 - t0);
		end
		chk("irq", 0, irq);
		bus(1, 7'h28, 8'h23);
		bus(1, 7'h2c, 8'hd0);
		wait_pe(t0);
		@(posedge ref_clk);
		chk("irq", 1, irq);
		chk("frozen pending", 0, update_pending);
		bus(0, 7'h2c, 8'hd0);
		bus(1, 7'h2c, 8'h10);
		bus(0, 7'h30, 8'h40, 8'h40);
		while (n_upd == 0)
			@(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
		chk("first update", 1, (t_upd - t_go) inside {[65524:65548]});
		chk("pending span", 1, (t_upd - t_pend) inside {[60:68]});
		chk("irq", 1, irq);
		bus(0, 7'h30, 8'h90, 8'h90);
		bus(1, 7'h28, 8'h63);
		@(posedge ref_clk);
		count_pe(200, k);
		chk("halt events", 0, k);
		chk("updates", 1, n_upd);
		$display("test divider done");
		print_verdict();
	end
endmodule : ryc_regs_bench
`default_nettype wire
